// file: rtl/dtf_pkg.sv
package dtf_pkg;

  // ==========================================================
  // bus and data widths
  localparam int DTF_AW  = 8;
  localparam int DTF_DW  = 16;
  localparam int DTF_NCH = 7;

  // ==========================================================
  // register offsets (byte addresses of the management map)
  localparam logic [7:0] DTF_ADDR_ALARM    = 8'h71;
  localparam logic [7:0] DTF_ADDR_WARN     = 8'h74;
  localparam logic [7:0] DTF_ADDR_THR_BASE = 8'h80;

  // ==========================================================
  // comparison channels, also threshold register index
  localparam int DTF_CH_RX_HI   = 0;
  localparam int DTF_CH_RX_LO   = 1;
  localparam int DTF_CH_TEMP_HI = 2;
  localparam int DTF_CH_TEMP_LO = 3;
  localparam int DTF_CH_VCC_HI  = 4;
  localparam int DTF_CH_VCC_LO  = 5;
  localparam int DTF_CH_BIAS_HI = 6;

  // set bit marks a channel that trips above its threshold
  localparam logic [6:0] DTF_CH_IS_HIGH = 7'h55;

  // ==========================================================
  // field positions inside the two status bytes
  localparam int DTF_BIT_RX_HI   = 7;
  localparam int DTF_BIT_RX_LO   = 6;
  localparam int DTF_BIT_TEMP_HI = 7;
  localparam int DTF_BIT_TEMP_LO = 6;
  localparam int DTF_BIT_VCC_HI  = 5;
  localparam int DTF_BIT_VCC_LO  = 4;
  localparam int DTF_BIT_BIAS_HI = 3;

  // ==========================================================
  // reset values: thresholds open so no flag trips at reset
  localparam logic [15:0] DTF_THR_RST_HIGH = 16'hFFFF;
  localparam logic [15:0] DTF_THR_RST_LOW  = 16'h0000;
  localparam logic [15:0] DTF_RDATA_RST    = 16'h0000;

endpackage

// file: rtl/dtf_cmp_if.sv
`timescale 1ns/10ps
interface dtf_cmp_if #(
  parameter int DW  = 16,
  parameter int NCH = 7
);
  logic [NCH-1:0][DW-1:0] value;
  logic [NCH-1:0][DW-1:0] thr;
  logic [NCH-1:0]         flag;

  modport top (output value, output thr, input flag);
  modport cmp (input value, input thr, output flag);
endinterface // dtf_cmp_if

// file: rtl/dtf_cmp.sv
`timescale 1ns/10ps
module dtf_cmp
  import dtf_pkg::*;
#(
  parameter int DW  = DTF_DW,
  parameter int NCH = DTF_NCH
)(
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic ce_in,
  dtf_cmp_if.cmp    cmp_if
);

  // ==========================================================
  // per-channel compare
  logic [NCH-1:0] flag_d;
  logic [NCH-1:0] flag_q;

  // the high/low map only knows the documented channels
  if (NCH > DTF_NCH)
  begin : g_nch_check
    $error("dtf_cmp: more channels than the high/low map holds");
  end

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++)
    begin : g_ch
      // strict compare: a value equal to its threshold is in range
      assign flag_d[gi] = DTF_CH_IS_HIGH[gi]
                        ? (cmp_if.value[gi] > cmp_if.thr[gi])
                        : (cmp_if.value[gi] < cmp_if.thr[gi]);
    end
  endgenerate

  // ==========================================================
  // flags are a live image of the compare, never latched
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      flag_q <= '0;
    else if (ce_in)
      flag_q <= flag_d;
  end

  assign cmp_if.flag = flag_q;

endmodule // dtf_cmp

// file: rtl/dtf_top.sv
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
// Functional notes
// - alarm byte bit 7 is set while rx power is above its high threshold.
// - alarm byte bit 6 is set while rx power is below its low threshold.
// - bits 0 to 5 of the alarm byte carry no flag.
// - byte 116 bit 7 is set while temperature is above its high threshold.
// - warning bit 6 is set while temperature is below its low threshold.
// - warning bit 5 is set while supply voltage is above its high threshold.
// - warning bit 4 is set while supply voltage is below its low threshold.
// - warning bit 3 is set while laser bias is above its high threshold.
// - the rx power alarm flags and reserved bits sit in the byte at 113.
module dtf_top
  import dtf_pkg::*;
#(
  parameter int DW = DTF_DW
)(
  input  wire logic                rstn_in,
  input  wire logic                mclk_in,
  input  wire logic                ce_in,
  input  wire logic [DW-1:0]       rx_pwr_in,
  input  wire logic [DW-1:0]       temp_in,
  input  wire logic [DW-1:0]       vcc_in,
  input  wire logic [DW-1:0]       bias_in,
  input  wire logic [DTF_AW-1:0]   addr_in,
  input  wire logic [DW-1:0]       wdata_in,
  input  wire logic                wr_in,
  input  wire logic                rd_in,
  output logic      [DW-1:0]       rdata_out,
  output logic      [7:0]          alarm_flags_out,
  output logic      [7:0]          warn_flags_out
);

  // ==========================================================
  // elaboration checks
  if (DW < 8)
  begin : g_dw_check
    $error("dtf_top: data width must hold a status byte");
  end

  // ==========================================================
  // reset release
  logic [1:0] rst_sync_q;
  logic       rst_n;

  // not gated by ce_in so a frozen block still leaves reset
  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  assign rst_n = rst_sync_q[1];

  // ==========================================================
  // threshold registers
  logic [DTF_NCH-1:0][DW-1:0] thr_q;
  logic [DTF_AW-1:0]          thr_idx;
  logic                       thr_hit;

  assign thr_idx = addr_in - DTF_ADDR_THR_BASE;
  assign thr_hit = (addr_in >= DTF_ADDR_THR_BASE)
                && (thr_idx < DTF_AW'(DTF_NCH));

  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < DTF_NCH; i++)
        thr_q[i] <= DTF_CH_IS_HIGH[i] ? DW'(DTF_THR_RST_HIGH)
                                      : DW'(DTF_THR_RST_LOW);
    end
    else if (ce_in && wr_in && thr_hit)
      thr_q[thr_idx] <= wdata_in;
  end

  // ==========================================================
  // compare bank
  dtf_cmp_if #(.DW(DW), .NCH(DTF_NCH)) cmp_bus ();

  assign cmp_bus.thr = thr_q;
  assign cmp_bus.value[DTF_CH_RX_HI]   = rx_pwr_in;
  assign cmp_bus.value[DTF_CH_RX_LO]   = rx_pwr_in;
  assign cmp_bus.value[DTF_CH_TEMP_HI] = temp_in;
  assign cmp_bus.value[DTF_CH_TEMP_LO] = temp_in;
  assign cmp_bus.value[DTF_CH_VCC_HI]  = vcc_in;
  assign cmp_bus.value[DTF_CH_VCC_LO]  = vcc_in;
  assign cmp_bus.value[DTF_CH_BIAS_HI] = bias_in;

  dtf_cmp #(
    .DW  (DW),
    .NCH (DTF_NCH)
  ) u_cmp (
    .clk_in   (mclk_in),
    .rst_n_in (rst_n),
    .ce_in    (ce_in),
    .cmp_if   (cmp_bus)
  );

  // ==========================================================
  // status byte assembly
  logic [7:0] alarm_byte;
  logic [7:0] warn_byte;

  always_comb
  begin
    alarm_byte = 8'h00;
    alarm_byte[DTF_BIT_RX_HI] = cmp_bus.flag[DTF_CH_RX_HI];
    alarm_byte[DTF_BIT_RX_LO] = cmp_bus.flag[DTF_CH_RX_LO];
    warn_byte = 8'h00;
    warn_byte[DTF_BIT_TEMP_HI] = cmp_bus.flag[DTF_CH_TEMP_HI];
    warn_byte[DTF_BIT_TEMP_LO] = cmp_bus.flag[DTF_CH_TEMP_LO];
    warn_byte[DTF_BIT_VCC_HI]  = cmp_bus.flag[DTF_CH_VCC_HI];
    warn_byte[DTF_BIT_VCC_LO]  = cmp_bus.flag[DTF_CH_VCC_LO];
    warn_byte[DTF_BIT_BIAS_HI] = cmp_bus.flag[DTF_CH_BIAS_HI];
  end

  // flag bytes are already flip-flop outputs of the compare bank
  assign alarm_flags_out = alarm_byte;
  assign warn_flags_out  = warn_byte;

  // ==========================================================
  // read port
  logic [DW-1:0] rdata_d;
  logic [DW-1:0] rdata_q;

  always_comb
  begin
    rdata_d = '0;
    if (addr_in == DTF_ADDR_ALARM)
      rdata_d = DW'(alarm_byte);
    else if (addr_in == DTF_ADDR_WARN)
      rdata_d = DW'(warn_byte);
    else if (thr_hit)
      rdata_d = thr_q[thr_idx];
  end

  // data stand only in the cycle after the strobe, zero otherwise; rdata_q holds while ce_in is low
  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= DW'(DTF_RDATA_RST);
    else if (ce_in)
      rdata_q <= rd_in ? rdata_d : '0;
  end

  assign rdata_out = rdata_q;

  // ==========================================================
  // checks
  AST_RX_HI: assert property (
    @(posedge mclk_in) disable iff (!rst_n)
    ce_in |=> alarm_flags_out[DTF_BIT_RX_HI]
              == $past(rx_pwr_in > thr_q[DTF_CH_RX_HI]))
    else $error("rx high alarm does not track compare");

  AST_RX_LO: assert property (
    @(posedge mclk_in) disable iff (!rst_n)
    ce_in |=> alarm_flags_out[DTF_BIT_RX_LO]
              == $past(rx_pwr_in < thr_q[DTF_CH_RX_LO]))
    else $error("rx low alarm does not track compare");

  AST_ALARM_RSVD: assert property (
    @(posedge mclk_in) disable iff (!rst_n)
    alarm_flags_out[5:0] == 6'h00)
    else $error("reserved alarm bits not zero");

  AST_TEMP_HI: assert property (
    @(posedge mclk_in) disable iff (!rst_n)
    ce_in |=> warn_flags_out[DTF_BIT_TEMP_HI]
              == $past(temp_in > thr_q[DTF_CH_TEMP_HI]))
    else $error("temp high warning does not track compare");

  AST_TEMP_LO: assert property (
    @(posedge mclk_in) disable iff (!rst_n)
    ce_in |=> warn_flags_out[DTF_BIT_TEMP_LO]
              == $past(temp_in < thr_q[DTF_CH_TEMP_LO]))
    else $error("temp low warning does not track compare");

  AST_VCC_HI: assert property (
    @(posedge mclk_in) disable iff (!rst_n)
    ce_in |=> warn_flags_out[DTF_BIT_VCC_HI]
              == $past(vcc_in > thr_q[DTF_CH_VCC_HI]))
    else $error("vcc high warning does not track compare");

  AST_VCC_LO: assert property (
    @(posedge mclk_in) disable iff (!rst_n)
    ce_in |=> warn_flags_out[DTF_BIT_VCC_LO]
              == $past(vcc_in < thr_q[DTF_CH_VCC_LO]))
    else $error("vcc low warning does not track compare");

  AST_BIAS_HI: assert property (
    @(posedge mclk_in) disable iff (!rst_n)
    ce_in |=> warn_flags_out[DTF_BIT_BIAS_HI]
              == $past(bias_in > thr_q[DTF_CH_BIAS_HI]))
    else $error("bias high warning does not track compare");

  AST_ALARM_READ: assert property (
    @(posedge mclk_in) disable iff (!rst_n)
    (ce_in && rd_in && addr_in == DTF_ADDR_ALARM)
    |=> rdata_out == DW'($past(alarm_flags_out)))
    else $error("alarm byte read returns wrong data");

  // a frozen block must hold flags and read data whatever the bus does
  AST_READ_KEEPS: assert property (
    @(posedge mclk_in) disable iff (!rst_n)
    !ce_in |=> $stable(warn_flags_out) && $stable(alarm_flags_out)
               && $stable(rdata_out))
    else $error("flags or read data moved while frozen");

  AST_WARN_RSVD: assert property (
    @(posedge mclk_in) disable iff (!rst_n)
    (ce_in && rd_in && addr_in == DTF_ADDR_WARN)
    |=> rdata_out[2:0] == 3'h0 && (rdata_out >> 8) == '0)
    else $error("reserved warning bits not zero on read");

endmodule // dtf_top

// file: verif/dtf_host.sv
`timescale 1ns/10ps
// ==========================================================
// host side: one-cycle strobes, never both, no wait states
module dtf_host
  import dtf_pkg::*;
(
  input  wire logic              clk_in,
  output logic      [DTF_AW-1:0] addr_out,
  output logic      [DTF_DW-1:0] wdata_out,
  output logic                   wr_out,
  output logic                   rd_out
);
  initial
  begin
    addr_out  = 8'h00;
    wdata_out = 16'h0000;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
  end

  // released lines show the inverse so stale values never match by luck
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= d;
    wr_out    <= 1'b1;
    @(posedge clk_in);
    wr_out    <= 1'b0;
    addr_out  <= ~a;
    wdata_out <= ~d;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge clk_in);
    rd_out   <= 1'b0;
    addr_out <= ~a;
  endtask
endmodule // dtf_host

// file: verif/dtf_top_tb.sv
`timescale 1ns/10ps
module dtf_top_tb
  import dtf_pkg::*;
;
  logic              mclk_in = 1'b0;
  logic              rstn_in = 1'b0;
  logic [DTF_AW-1:0] addr;
  logic [DTF_DW-1:0] wdata;
  logic [DTF_DW-1:0] rdata;
  logic              wr;
  logic              rd;
  logic              rd_seen = 1'b0;
  logic              ce = 1'b1;
  logic [7:0]        alarm_flags;
  logic [7:0]        warn_flags;
  logic [15:0]       flg_q [$];
  logic [15:0]       meas [4] = '{default: 16'h0000};
  logic [15:0]       thr [7];
  logic [7:0]        adr_q [$];
  logic [15:0]       exp_q [$];
  logic [31:0]       lf = 32'h0001_7552;
  int                err_count = 0;
  int                n_tests = 0;

  always #25 mclk_in = ~mclk_in;

  dtf_host host_u (.clk_in(mclk_in), .addr_out(addr), .wdata_out(wdata),
                   .wr_out(wr), .rd_out(rd));

  dtf_top dut_u (.rstn_in(rstn_in), .mclk_in(mclk_in), .ce_in(ce),
    .rx_pwr_in(meas[0]), .temp_in(meas[1]), .vcc_in(meas[2]),
    .bias_in(meas[3]), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdata), .alarm_flags_out(alarm_flags),
    .warn_flags_out(warn_flags));

  // ==========================================================
  // reference model
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // strict compares: equal to the threshold raises nothing
  function automatic logic [15:0] model(input logic [7:0] a);
    if (a == 8'h71)
      return {8'h00, meas[0] > thr[0], meas[0] < thr[1], 6'h00};
    if (a == 8'h74)
      return {8'h00, meas[1] > thr[2], meas[1] < thr[3],
              meas[2] > thr[4], meas[2] < thr[5], meas[3] > thr[6], 3'h0};
    if (a >= 8'h80 && a <= 8'h86)
      return thr[a[2:0]];
    return 16'h0000;
  endfunction

  // inputs stay put during a read, so the flag bytes are noted with it
  task automatic rd_chk(input logic [7:0] a);
    logic [15:0] fa;
    logic [15:0] fw;
    fa = model(8'h71);
    fw = model(8'h74);
    exp_q.push_back(model(a));
    adr_q.push_back(a);
    flg_q.push_back({fa[7:0], fw[7:0]});
    host_u.rd(a);
  endtask

  task automatic wr_thr(input int ch, input logic [15:0] v);
    thr[ch] = v;
    host_u.wr(8'h80 + 8'(ch), v);
  endtask

  // two edges so the compare has landed before the next read strobe
  task automatic set_meas(input int i, input logic [15:0] v);
    @(posedge mclk_in);
    meas[i] <= v;
    @(posedge mclk_in);
  endtask

  // ==========================================================
  // result watcher
  always @(posedge mclk_in)
  begin
    if (rd_seen)
    begin
      n_tests += 2;
      if (rdata !== exp_q[0])
      begin
        err_count++;
        $display("unexpected rdata at %h: expected %h seen %h",
                 adr_q[0], exp_q[0], rdata);
      end
      if ({alarm_flags, warn_flags} !== flg_q[0])
      begin
        err_count++;
        $display("unexpected flags at %h: expected %h seen %h",
                 adr_q[0], flg_q[0], {alarm_flags, warn_flags});
      end
      void'(exp_q.pop_front());
      void'(adr_q.pop_front());
      void'(flg_q.pop_front());
    end
    else if (rstn_in)
    begin
      n_tests++;
      if (rdata !== 16'h0000)
      begin
        err_count++;
        $display("unexpected idle rdata: expected 0000 seen %h", rdata);
      end
    end
    rd_seen <= rd;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge mclk_in);
    err_count++;
    $display("watchdog expired");
    report_and_stop();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    int          ch;
    logic [15:0] v;
    for (int i = 0; i < 7; i++)
      thr[i] = (i % 2 == 0) ? 16'hFFFF : 16'h0000;
    repeat (3) @(posedge mclk_in);
    rstn_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    for (int a = 8'h70; a <= 8'h87; a++)
      rd_chk(8'(a));
    $display("test reset_map done");
    repeat (200)
    begin
      lf = nxt(lf);
      ch = int'(lf[2:0]) % 7;
      lf = nxt(lf);
      wr_thr(ch, lf[15:0]);
      lf = nxt(lf);
      v = lf[18] ? lf[15:0] : thr[ch] + {{14{lf[17]}}, lf[17:16]};
      set_meas(ch / 2, v);
      rd_chk(8'h71);
      rd_chk(8'h74);
      rd_chk(8'h80 + 8'(ch));
    end
    $display("test random_compare done");
    wr_thr(0, 16'h1000);
    set_meas(0, 16'h2000);
    repeat (3) rd_chk(8'h71);
    host_u.wr(8'h71, 16'h0000);
    host_u.wr(8'h74, 16'hFFFF);
    host_u.wr(8'h00, 16'hFFFF);
    rd_chk(8'h71);
    rd_chk(8'h74);
    rd_chk(8'h00);
    set_meas(0, 16'h1000);
    rd_chk(8'h71);
    $display("test hold_and_ignore done");
    v = model(8'h71);
    @(posedge mclk_in);
    ce <= 1'b0;
    set_meas(0, 16'h2000);
    host_u.wr(8'h80, 16'h0000);
    n_tests++;
    if (alarm_flags !== v[7:0])
    begin
      err_count++;
      $display("unexpected alarm_flags frozen: expected %h seen %h",
               v[7:0], alarm_flags);
    end
    @(posedge mclk_in);
    ce <= 1'b1;
    rd_chk(8'h80);
    rd_chk(8'h71);
    $display("test freeze done");
    @(posedge mclk_in);
    rstn_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    rstn_in <= 1'b1;
    for (int i = 0; i < 7; i++)
      thr[i] = (i % 2 == 0) ? 16'hFFFF : 16'h0000;
    repeat (4) @(posedge mclk_in);
    for (int a = 8'h70; a <= 8'h87; a++)
      rd_chk(8'(a));
    $display("test mid_reset done");
    repeat (4) @(posedge mclk_in);
    report_and_stop();
  end
endmodule // dtf_top_tb
